// file: design/psta_defs.vh
// Constants for the program space table access block
`ifndef PSTA_DEFS_VH
`define PSTA_DEFS_VH
`define PSTA_ADDR_W 24
`define PSTA_PC_W 23
`define PSTA_WORD_W 24
`define PSTA_DATA_W 16
`define PSTA_USER_MAX 24'h7ffffe
`define PSTA_CFG_BIT 23
`define PSTA_PAGE_CFG_BIT 7
`define PSTA_PSV_PAGE_W 9
`define PSTA_PSV_OFS_W 15
`define PSTA_SRC_PC 2'h0
`define PSTA_SRC_TBL 2'h1
`define PSTA_SRC_PSV 2'h2
`define PSTA_OP_RDL 2'h0
`define PSTA_OP_RDH 2'h1
`define PSTA_OP_WTL 2'h2
`define PSTA_OP_WTH 2'h3
`endif

// file: design/psta_table_access.v
// Program space address construction and table data path
`timescale 1ns/1ps
`include "psta_defs.vh"

module psta_table_access #(
	parameter ADDR_W = 24,
	parameter DATA_W = 16
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Access request from the core
	input wire req_i,
	input wire [1:0] src_i,
	input wire [1:0] tbl_op_i,
	input wire tbl_byte_i,
	input wire [22:0] pc_i,
	input wire [15:0] ea_i,
	input wire [7:0] table_page_register_i,
	input wire [7:0] psv_page_i,
	input wire program_space_visibility_i,
	input wire [15:0] wr_data_i,
	// Program memory port
	output reg pm_req_o,
	output reg pm_we_o,
	output reg [1:0] pm_lane_o,
	output reg [23:0] pm_addr_o,
	output reg [23:0] pm_wdata_o,
	input wire [23:0] pm_rdata_i,
	input wire pm_ack_i,
	// Answer to the core
	output reg rd_valid_o,
	output reg [15:0] rd_data_o,
	output wire psv_hit_o
);

reg [23:0] nxt_addr;
reg [23:0] nxt_wdata;
reg [1:0] nxt_lane;
reg nxt_we;
reg [1:0] op_ff;
reg byte_ff;
reg tbl_ff;
reg busy_ff;
reg [15:0] nxt_rdata;
reg ea_sel_ff;
wire take;
wire done;
wire [23:0] pc_addr;
wire [23:0] tbl_addr;
wire [23:0] psv_addr;
wire [7:0] lo_byte;
wire [7:0] hi_byte;
wire [23:0] wt_data;
genvar gi;

// Accept when idle, finish on answer
assign take = req_i & ~busy_ff;
assign done = busy_ff & pm_ack_i;

assign psv_hit_o = program_space_visibility_i & ea_i[15];

assign pc_addr = {1'b0, pc_i[22:1], 1'b0};
assign tbl_addr = {table_page_register_i, ea_i[15:1], 1'b0};
assign psv_addr = {1'b0, psv_page_i, ea_i[14:1], 1'b0};

// Byte picked by select, per bit
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
		assign lo_byte[gi] = ea_sel_ff ? pm_rdata_i[gi + 8] : pm_rdata_i[gi];
		assign hi_byte[gi] = ~ea_sel_ff & pm_rdata_i[gi + 16];
	end
endgenerate

// Write data lanes, per bit
generate
	for (gi = 0; gi < 24; gi = gi + 1) begin : g_wdata
		if (gi < 16) begin : g_low
			assign wt_data[gi] = wr_data_i[gi] & (tbl_op_i == `PSTA_OP_WTL);
		end else begin : g_high
			assign wt_data[gi] = wr_data_i[gi - 16] & (tbl_op_i == `PSTA_OP_WTH);
		end
	end
endgenerate

always @* begin
	nxt_addr = 24'h000000;
	nxt_wdata = 24'h000000;
	nxt_lane = 2'h3;
	nxt_we = 1'b0;
	case (src_i)
	`PSTA_SRC_PC: begin
		nxt_addr = pc_addr;
	end
	`PSTA_SRC_TBL: begin
		nxt_addr = tbl_addr;
		case (tbl_op_i)
		`PSTA_OP_RDL: nxt_lane = 2'h1;
		`PSTA_OP_RDH: nxt_lane = 2'h2;
		`PSTA_OP_WTL: begin
			nxt_we = 1'b1;
			nxt_lane = 2'h1;
			nxt_wdata = wt_data;
		end
		`PSTA_OP_WTH: begin
			nxt_we = 1'b1;
			nxt_lane = 2'h2;
			nxt_wdata = wt_data;
		end
		default: nxt_lane = 2'h1;
		endcase
	end
	`PSTA_SRC_PSV: begin
		nxt_addr = psv_addr;
		nxt_lane = 2'h1;
	end
	default: nxt_addr = 24'h000000;
	endcase
	// Bit 23 forced low off table path
	if (src_i != `PSTA_SRC_TBL)
		nxt_addr[`PSTA_CFG_BIT] = 1'b0;
	nxt_addr[0] = 1'b0;
end

always @* begin
	nxt_rdata = 16'h0000;
	if (!tbl_ff) begin
		nxt_rdata = pm_rdata_i[15:0];
	end else if (op_ff == `PSTA_OP_RDL) begin
		if (!byte_ff)
			nxt_rdata = pm_rdata_i[15:0];
		else
			nxt_rdata = {8'h00, lo_byte};
	end else if (op_ff == `PSTA_OP_RDH) begin
		// Byte high read select one zero
		if (byte_ff)
			nxt_rdata = {8'h00, hi_byte};
		else
			nxt_rdata = {8'h00, pm_rdata_i[23:16]};
	end
end

// Request level until memory answers
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		pm_req_o <= 1'b0;
	end else if (take) begin
		pm_req_o <= 1'b1;
	end else if (done) begin
		pm_req_o <= 1'b0;
	end
end

// Write flag of the pending access
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		pm_we_o <= 1'b0;
	end else if (take) begin
		pm_we_o <= nxt_we;
	end else if (done) begin
		pm_we_o <= 1'b0;
	end
end

// Access pending
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		busy_ff <= 1'b0;
	end else if (take) begin
		busy_ff <= 1'b1;
	end else if (done) begin
		busy_ff <= 1'b0;
	end
end

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		pm_lane_o <= 2'h0;
	end else if (take) begin
		pm_lane_o <= nxt_lane;
	end else if (done) begin
		pm_lane_o <= 2'h0;
	end
end

always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		pm_addr_o <= 24'h000000;
	end else if (take) begin
		pm_addr_o <= nxt_addr;
	end else if (done) begin
		pm_addr_o <= 24'h000000;
	end
end

// Write data of the pending access
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		pm_wdata_o <= 24'h000000;
	end else if (take) begin
		pm_wdata_o <= nxt_wdata;
	end else if (done) begin
		pm_wdata_o <= 24'h000000;
	end
end

// Table operation kept for the answer
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		op_ff <= 2'h0;
	end else if (take) begin
		op_ff <= tbl_op_i;
	end
end

// Byte size kept for the answer
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		byte_ff <= 1'b0;
	end else if (take) begin
		byte_ff <= tbl_byte_i;
	end
end

// Byte select from EA bit zero
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		ea_sel_ff <= 1'b0;
	end else if (take) begin
		ea_sel_ff <= ea_i[0];
	end
end

// Table source kept for the answer
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		tbl_ff <= 1'b0;
	end else if (take) begin
		tbl_ff <= (src_i == `PSTA_SRC_TBL);
	end
end

// Read strobe, one cycle, not on writes
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		rd_valid_o <= 1'b0;
	end else if (done) begin
		rd_valid_o <= ~pm_we_o;
	end else begin
		rd_valid_o <= 1'b0;
	end
end

// Read data held until the next read answer
always @(posedge mclk_i or posedge rst_i) begin
	if (rst_i) begin
		rd_data_o <= 16'h0000;
	end else if (done & ~pm_we_o) begin
		rd_data_o <= nxt_rdata;
	end
end

endmodule

// file: bench/psta_chk.sv
// Checker on the table access ports
`timescale 1ns/1ps
module psta_chk(
	input wire mclk_i, rst_i, req_i, pm_req_o, pm_we_o, pm_ack_i, rd_valid_o,
	input wire [1:0] src_i, tbl_op_i,
	input wire [22:0] pc_i,
	input wire [15:0] ea_i, wr_data_i,
	input wire [7:0] table_page_register_i, psv_page_i,
	input wire [23:0] pm_addr_o, pm_wdata_o
);
wire a = req_i && !pm_req_o;
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
AST_PC: assert property (a && src_i == 0 |=> pm_addr_o == {1'b0, $past(pc_i[22:1]), 1'b0})
	else $error("pc");
AST_TB: assert property (a && src_i == 1 |=>
	pm_addr_o == {$past(table_page_register_i), $past(ea_i[15:1]), 1'b0}) else $error("tb");
AST_PS: assert property (a && src_i == 2 |=>
	pm_addr_o == {1'b0, $past(psv_page_i), $past(ea_i[14:1]), 1'b0}) else $error("ps");
AST_HLD: assert property (pm_req_o && !pm_ack_i |=> pm_req_o && $stable(pm_addr_o))
	else $error("hold");
AST_RD: assert property (pm_ack_i && pm_req_o && !pm_we_o |=> rd_valid_o && !pm_req_o)
	else $error("rd");
AST_WR: assert property (pm_ack_i && pm_req_o && pm_we_o |=> !rd_valid_o && !pm_req_o)
	else $error("wr");
AST_WL: assert property (a && src_i == 1 && tbl_op_i == 2 |=>
	pm_we_o && pm_wdata_o[15:0] == $past(wr_data_i)) else $error("wl");
AST_WH: assert property (a && src_i == 1 && tbl_op_i == 3 |=>
	pm_we_o && pm_wdata_o[23:16] == $past(wr_data_i[7:0])) else $error("wh");
AST_B23: assert property (a && src_i != 1 |=> !pm_addr_o[23])
	else $error("bit 23 set off table path");
AST_AL: assert property (pm_req_o |-> !pm_addr_o[0])
	else $error("odd word address");
AST_VL1: assert property (rd_valid_o |=> !rd_valid_o)
	else $error("read strobe too long");
endmodule

// file: bench/psta_mem.sv
// Program memory model
`timescale 1ns/1ps
module psta_mem(
	input wire mclk_i, req_i, we_i,
	input wire [1:0] lane_i, dly_i,
	input wire [23:0] addr_i, wd_i,
	output reg ack_o = 0,
	output reg [23:0] rd_o = 0
);
reg [23:0] m [0:15];
reg [1:0] n = 0;
integer i;
initial for (i = 0; i < 16; i++) m[i] = 24'h9e37b5 * (i + 1);
always @(posedge mclk_i) begin
	ack_o <= 0;
	rd_o <= ~rd_o;
	if (req_i && !ack_o) begin
		n <= n + 1;
		if (n == dly_i) begin
			n <= 0;
			ack_o <= 1;
			rd_o <= m[addr_i[4:1]];
			if (we_i && lane_i[0]) m[addr_i[4:1]][15:0] <= wd_i[15:0];
			if (we_i && lane_i[1]) m[addr_i[4:1]][23:16] <= wd_i[23:16];
		end
	end
end
endmodule

// file: bench/tb_top.sv
// Testbench for table access
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((e) !== (s)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
reg mclk_i = 0, rst_i = 1, req_i = 0, tbl_byte_i = 0, program_space_visibility_i = 0;
reg [1:0] src_i = 0, tbl_op_i = 0, dly = 0;
reg [22:0] pc_i = 0;
reg [15:0] ea_i = 0, wr_data_i = 0, lf = 16'd25113;
reg [7:0] table_page_register_i = 0, psv_page_i = 0;
reg [23:0] sh [0:15];
wire pm_req_o, pm_we_o, pm_ack_i, rd_valid_o, psv_hit_o;
wire [1:0] pm_lane_o;
wire [23:0] pm_addr_o, pm_wdata_o, pm_rdata_i;
wire [15:0] rd_data_o;
int fails = 0, checked = 0, i, k;
always #12.5 mclk_i = ~mclk_i;
psta_table_access i_dut(.*);
psta_mem u_mem(.mclk_i(mclk_i), .req_i(pm_req_o), .we_i(pm_we_o), .lane_i(pm_lane_o),
	.dly_i(dly), .addr_i(pm_addr_o), .wd_i(pm_wdata_o), .ack_o(pm_ack_i), .rd_o(pm_rdata_i));
function [15:0] nx(input [15:0] v);
	nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
function [15:0] ex(input [1:0] s, o, input b, input [15:0] e, input [23:0] w);
	ex = (s != 1 || (o == 0 && !b)) ? w[15:0] : o == 0 ? (e[0] ? w[15:8] : w[7:0]) :
		(b && e[0]) ? 16'h0 : w[23:16];
endfunction
task wrap_up;
	begin
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	end
endtask
task go(input [1:0] s, o, input b);
	reg [3:0] x;
	reg [23:0] w;
	begin
		@(negedge mclk_i);
		{src_i, tbl_op_i, tbl_byte_i, ea_i, pc_i} = {s, o, b, lf, lf, lf[6:0]};
		{table_page_register_i, psv_page_i} = lf;
		{wr_data_i, program_space_visibility_i, dly} = {lf, lf[2:0]};
		x = s ? ea_i[4:1] : pc_i[4:1];
		w = sh[x];
		req_i = 1;
		lf = nx(lf);
		@(negedge mclk_i);
		req_i = 0;
		k = 0;
		while (pm_ack_i !== 1'b1 && k < 9) begin @(negedge mclk_i); k++; end
		@(negedge mclk_i);
		if (s == 1 && o == 2) sh[x][15:0] = wr_data_i;
		if (s == 1 && o == 3) sh[x][23:16] = wr_data_i[7:0];
		`CK("vld", rd_valid_o, !(s == 1 && o[1]))
		`CK("hit", psv_hit_o, program_space_visibility_i & ea_i[15])
		if (!(s == 1 && o[1])) `CK("rd", ex(s, o, b, ea_i, w), rd_data_o)
	end
endtask
initial begin
	for (i = 0; i < 16; i++) sh[i] = 24'h9e37b5 * (i + 1);
	repeat (20) @(negedge mclk_i);
	rst_i = 0;
	for (i = 0; i < 88; i++) begin
		go(i < 8 ? 1 : lf % 3, i < 8 ? i[2:1] : lf[5:4], i < 8 ? i[0] : lf[6]);
		$display("test %0d done", i);
	end
	wrap_up;
end
initial begin
	#40000;
	fails++;
	wrap_up;
end
endmodule
bind psta_table_access psta_chk u_chk(.*);
